// ### design/eag_effective_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "eag_consts.svh"

// Notes on behaviour
// (RULE1) abs,X: bytes2-3 plus X, data bank
// (RULE2) abs,Y: bytes2-3 plus Y, data bank
// (RULE3) abs indirect: bank0 pointer loads PC
// (RULE4) jump long indirect also loads program bank
// (RULE5) long indexed: 24-bit base plus X
// (RULE6) absolute long: bytes2-4 are address
// (RULE7) block move: dest byte2:Y, source byte3:X
// (RULE8) accumulator holds byte count minus one
// (RULE9) block move copies dest bank to data bank
// (RULE10) step indexes, count down, PC+3 at end
// (RULE11) (d,x): D+op+X pointer, data bank prefix
// (RULE12) d,X: D+op+X in bank 0
// (RULE13) d,Y: D+op+Y in bank 0
// (RULE14) (d),Y: pointer word, data bank, plus Y
// (RULE15) [d],Y: 24-bit pointer plus Y
// (RULE16) [d]: 24-bit pointer is address
// (RULE17) (d): pointer low 16, data bank high
// (RULE18) direct: D plus operand, bank 0
// (RULE19) nonzero direct low byte adds one cycle
// (RULE20) immediate: one or two operand bytes
// (RULE21) long relative: signed offset plus next PC
// (RULE22) branch loads PC, push-relative pushes sum
module eag_effective_address_generator
  import eag_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire eag_mode_t   mode,
  input  wire logic [7:0]  op_byte2,
  input  wire logic [7:0]  op_byte3,
  input  wire logic [7:0]  op_byte4,
  input  wire logic        wide_mode,
  input  wire logic [15:0] index_x,
  input  wire logic [15:0] index_y,
  input  wire logic [15:0] direct_reg,
  input  wire logic [15:0] accum,
  input  wire logic [15:0] prog_counter,
  input  wire logic        ptr_valid,
  input  wire logic [23:0] ptr_data,
  output var  logic [23:0] eff_addr,
  output var  logic        addr_valid,
  output var  logic [23:0] ptr_addr,
  output var  logic        ptr_req,
  output var  logic        ptr_long,
  output var  logic [15:0] operand,
  output var  logic        operand_valid,
  output var  logic        pc_load,
  output var  logic [15:0] next_pc,
  output var  logic        pbr_load,
  output var  logic [7:0]  program_bank_reg,
  output var  logic [7:0]  data_bank_reg,
  output var  logic        push_req,
  output var  logic [15:0] push_data,
  output var  logic        move_step,
  output var  logic [15:0] move_next_x,
  output var  logic [15:0] move_next_y,
  output var  logic [15:0] move_next_count,
  output var  logic        move_done
);

  // start stands one cycle only, so the mode is kept here for the penalty
  // and pointer-wait states; the core must also hold the operand bytes,
  // the index registers and direct_reg steady until the result appears
  eag_state_t  state;
  eag_state_t  next_state;
  eag_mode_t   held_mode;

  // operand fields and sums shared by the modes
  wire logic [15:0] abs_word  = {op_byte3, op_byte2};
  wire logic [23:0] long_word = {op_byte4, op_byte3, op_byte2};
  wire logic [15:0] dir_base  = direct_reg + {8'h00, op_byte2};
  wire logic [15:0] dir_x     = dir_base + index_x;
  wire logic [15:0] dir_y     = dir_base + index_y;
  wire logic [15:0] abs_x     = abs_word + index_x; // RULE1
  wire logic [15:0] abs_y     = abs_word + index_y; // RULE2
  wire logic [23:0] long_x    = long_word + {8'h00, index_x}; // RULE5
  wire logic [15:0] rel_sum   = prog_counter + {op_byte3, op_byte2}; // RULE21
  wire logic        dl_nonzero = direct_reg[7:0] != `EAG_DL_ZERO; // RULE19

  // which modes are direct-page, and which go through a fetched pointer
  wire logic is_direct =
    (mode == EAG_DIR_IDX_IND) || (mode == EAG_DIR_X) || (mode == EAG_DIR_Y) ||
    (mode == EAG_DIR_IND_IDX_Y) || (mode == EAG_DIR_IND_LONG_IDX_Y) ||
    (mode == EAG_DIR_IND_LONG) || (mode == EAG_DIR_IND) || (mode == EAG_DIR);
  wire logic needs_ptr =
    (mode == EAG_ABS_IND) || (mode == EAG_JUMP_LONG_IND) || (mode == EAG_DIR_IDX_IND) ||
    (mode == EAG_DIR_IND_IDX_Y) || (mode == EAG_DIR_IND_LONG_IDX_Y) ||
    (mode == EAG_DIR_IND_LONG) || (mode == EAG_DIR_IND);
  wire logic held_needs_ptr =
    (held_mode == EAG_ABS_IND) || (held_mode == EAG_JUMP_LONG_IND) ||
    (held_mode == EAG_DIR_IDX_IND) || (held_mode == EAG_DIR_IND_IDX_Y) ||
    (held_mode == EAG_DIR_IND_LONG_IDX_Y) || (held_mode == EAG_DIR_IND_LONG) ||
    (held_mode == EAG_DIR_IND);
  wire logic long_ptr =
    (mode == EAG_JUMP_LONG_IND) || (mode == EAG_DIR_IND_LONG_IDX_Y) || (mode == EAG_DIR_IND_LONG);

  // the penalty belongs to direct-page modes only; testing the low byte
  // alone would send an absolute indexed take through the penalty state,
  // which would then report the direct-page sum as its address
  wire logic take_penalty = is_direct && dl_nonzero; // RULE19

  // pointer location in bank 0
  wire logic [15:0] ptr_loc =
    (mode == EAG_ABS_IND || mode == EAG_JUMP_LONG_IND) ? abs_word : // RULE3
    (mode == EAG_DIR_IDX_IND) ? dir_x : dir_base; // RULE11

  // address once the pointer has arrived
  // word pointers use the low 16 bits only; the fetched bank byte is ignored
  wire logic [23:0] ptr_result =
    (held_mode == EAG_DIR_IDX_IND)        ? {data_bank_reg, ptr_data[15:0]} : // RULE11
    (held_mode == EAG_DIR_IND_IDX_Y)      ? {data_bank_reg, ptr_data[15:0]} + {8'h00, index_y} : // RULE14
    (held_mode == EAG_DIR_IND_LONG_IDX_Y) ? ptr_data + {8'h00, index_y} : // RULE15
    (held_mode == EAG_DIR_IND_LONG)       ? ptr_data : // RULE16
    {data_bank_reg, ptr_data[15:0]}; // RULE17

  // direct-page modes without a pointer
  // the sums come from the inputs in the penalty cycle, not from those at the take
  wire logic [23:0] direct_result =
    (held_mode == EAG_DIR_X) ? {`EAG_BANK_ZERO, dir_x} : // RULE12
    (held_mode == EAG_DIR_Y) ? {`EAG_BANK_ZERO, dir_y} : // RULE13
    {`EAG_BANK_ZERO, dir_base}; // RULE18

  // block move bookkeeping, one byte per start
  wire logic        move_asc   = mode == EAG_BLOCK_MOVE_ASC;
  wire logic        move_mode  = move_asc || (mode == EAG_BLOCK_MOVE_DESC);
  wire logic [15:0] step_x     = move_asc ? index_x + `EAG_ONE16 : index_x - `EAG_ONE16; // RULE10
  wire logic [15:0] step_y     = move_asc ? index_y + `EAG_ONE16 : index_y - `EAG_ONE16; // RULE10
  wire logic        last_byte  = accum == `EAG_ZERO16; // RULE8
  wire logic [15:0] step_count = last_byte ? accum : accum - `EAG_ONE16; // RULE10

  // state sequencing; penalty and pointer wait hold the held mode
  always_comb
  begin
    next_state = state;
    case (state)
      EAG_IDLE:
      begin
        if (start && take_penalty)
          next_state = EAG_PENALTY; // RULE19
        else if (start && needs_ptr)
          next_state = EAG_PTR_WAIT;
      end
      EAG_PENALTY:
      begin
        next_state = held_needs_ptr ? EAG_PTR_WAIT : EAG_IDLE;
      end
      EAG_PTR_WAIT:
      begin
        if (ptr_valid)
          next_state = EAG_IDLE;
      end
      default:
      begin
        next_state = EAG_IDLE;
      end
    endcase
  end

  // outside idle a start is simply not seen; there is no busy flag, the core
  // is expected to wait for the result pulse before asking again
  wire logic idle_start = (state == EAG_IDLE) && start;
  wire logic fire_ptr   = ((state == EAG_IDLE) && start && needs_ptr && !take_penalty) ||
                          ((state == EAG_PENALTY) && held_needs_ptr);
  wire logic ptr_done   = (state == EAG_PTR_WAIT) && ptr_valid;
  wire logic held_jump  = (held_mode == EAG_ABS_IND) || (held_mode == EAG_JUMP_LONG_IND);

  // state and mode capture
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= EAG_IDLE;
      held_mode <= EAG_DIR;
    end
    else
    begin
      state <= next_state;
      if (idle_start)
        held_mode <= mode;
    end
  end

  // pointer request; pointer location kept while waiting
  // ptr_addr is latched at the take, not at the request, so the location
  // seen by memory does not depend on the penalty cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ptr_req  <= 1'b0;
      ptr_addr <= 24'h00_0000;
      ptr_long <= 1'b0;
    end
    else
    begin
      ptr_req <= fire_ptr;
      if (idle_start)
      begin
        ptr_addr <= {`EAG_BANK_ZERO, ptr_loc}; // RULE3
        ptr_long <= long_ptr;
      end
    end
  end

  // effective address result
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eff_addr   <= 24'h00_0000;
      addr_valid <= 1'b0;
    end
    else
    begin
      addr_valid <= 1'b0;
      if (ptr_done && !held_jump)
      begin
        eff_addr   <= ptr_result;
        addr_valid <= 1'b1;
      end
      else if ((state == EAG_PENALTY) && !held_needs_ptr)
      begin
        eff_addr   <= direct_result; // RULE19
        addr_valid <= 1'b1;
      end
      else if (idle_start && !needs_ptr && !take_penalty)
      begin
        addr_valid <= 1'b1;
        case (mode)
          EAG_ABS_X:             eff_addr <= {data_bank_reg, abs_x}; // RULE1
          EAG_ABS_Y:             eff_addr <= {data_bank_reg, abs_y}; // RULE2
          EAG_LONG_INDEXED_MODE: eff_addr <= long_x; // RULE5
          EAG_ABS_LONG:          eff_addr <= long_word; // RULE6
          EAG_BLOCK_MOVE_ASC,
          EAG_BLOCK_MOVE_DESC:   eff_addr <= {op_byte3, index_x}; // RULE7
          EAG_DIR_X:             eff_addr <= {`EAG_BANK_ZERO, dir_x}; // RULE12
          EAG_DIR_Y:             eff_addr <= {`EAG_BANK_ZERO, dir_y}; // RULE13
          EAG_DIR:               eff_addr <= {`EAG_BANK_ZERO, dir_base}; // RULE18
          default:               addr_valid <= 1'b0;
        endcase
      end
    end
  end

  // immediate operand; upper byte zero in 8-bit operation
  // zero fill lets the core load a full word in either width
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      operand       <= 16'h0000;
      operand_valid <= 1'b0;
    end
    else
    begin
      operand_valid <= idle_start && (mode == EAG_IMMEDIATE);
      if (idle_start && (mode == EAG_IMMEDIATE))
        operand <= wide_mode ? abs_word : {8'h00, op_byte2}; // RULE20
    end
  end

  // program counter and bank loads; relative modes leave the bank alone
  // the branches never collide: a pointer result only ends a wait state,
  // the others only happen on a take from idle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_load          <= 1'b0;
      next_pc          <= 16'h0000;
      pbr_load         <= 1'b0;
      program_bank_reg <= `EAG_PBR_RST;
      push_req         <= 1'b0;
      push_data        <= 16'h0000;
    end
    else
    begin
      pc_load  <= 1'b0;
      pbr_load <= 1'b0;
      push_req <= 1'b0;
      if (ptr_done && held_jump)
      begin
        pc_load <= 1'b1;
        next_pc <= ptr_data[15:0]; // RULE3
        if (held_mode == EAG_JUMP_LONG_IND)
        begin
          pbr_load         <= 1'b1;
          program_bank_reg <= ptr_data[23:16]; // RULE4
        end
      end
      else if (idle_start && (mode == EAG_BRANCH_LONG))
      begin
        pc_load <= 1'b1;
        next_pc <= rel_sum; // RULE22
      end
      else if (idle_start && move_mode && last_byte)
      begin
        pc_load <= 1'b1;
        next_pc <= prog_counter + `EAG_MOVE_PC_STEP; // RULE10
      end
      if (idle_start && (mode == EAG_PUSH_RELATIVE_ADDRESS))
      begin
        push_req  <= 1'b1;
        push_data <= rel_sum; // RULE22
      end
    end
  end

  // block move register updates; the destination is data_bank_reg over Y
  // one byte per start: the core feeds move_next_* back and starts again
  // until move_done; a count already at zero stays there instead of
  // wrapping, which is what ends the move
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_bank_reg   <= `EAG_DBR_RST;
      move_step       <= 1'b0;
      move_next_x     <= 16'h0000;
      move_next_y     <= 16'h0000;
      move_next_count <= 16'h0000;
      move_done       <= 1'b0;
    end
    else
    begin
      move_step <= idle_start && move_mode;
      move_done <= idle_start && move_mode && last_byte;
      if (idle_start && move_mode)
      begin
        data_bank_reg   <= op_byte2; // RULE9
        move_next_x     <= step_x;
        move_next_y     <= step_y;
        move_next_count <= step_count;
      end
    end
  end

endmodule // eag_effective_address_generator
`default_nettype wire

// ### design/eag_consts.svh
`ifndef EAG_CONSTS_SVH
`define EAG_CONSTS_SVH
// reset values of the bank registers, and zero bank and low-byte constants
`define EAG_DBR_RST      8'h00
`define EAG_PBR_RST      8'h00
`define EAG_BANK_ZERO    8'h00
`define EAG_DL_ZERO      8'h00
// program counter step once a block move completes
`define EAG_MOVE_PC_STEP 16'h0003
`define EAG_ONE16        16'h0001
`define EAG_ZERO16       16'h0000
`endif

// ### design/eag_pkg.sv
package eag_pkg;
  // addressing mode select from the sequencer
  typedef enum logic [4:0] {
    EAG_ABS_X,
    EAG_ABS_Y,
    EAG_ABS_IND,
    EAG_JUMP_LONG_IND,
    EAG_LONG_INDEXED_MODE,
    EAG_ABS_LONG,
    EAG_BLOCK_MOVE_ASC,
    EAG_BLOCK_MOVE_DESC,
    EAG_DIR_IDX_IND,
    EAG_DIR_X,
    EAG_DIR_Y,
    EAG_DIR_IND_IDX_Y,
    EAG_DIR_IND_LONG_IDX_Y,
    EAG_DIR_IND_LONG,
    EAG_DIR_IND,
    EAG_DIR,
    EAG_IMMEDIATE,
    EAG_BRANCH_LONG,
    EAG_PUSH_RELATIVE_ADDRESS
  } eag_mode_t;

  // sequencing inside one address calculation
  typedef enum logic [1:0] {
    EAG_IDLE,
    EAG_PENALTY,
    EAG_PTR_WAIT
  } eag_state_t;
endpackage

// ### sim/eag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        ptr_req,
  input  wire logic [23:0] ptr_addr,
  output var  logic        ptr_valid,
  output var  logic [23:0] ptr_data
);
  logic [2:0]  wait_cnt;
  logic [23:0] loc;

  // pointer memory: answers after one or three idle cycles; the bus walks
  // a junk pattern otherwise so a stale read can never look right
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      ptr_valid <= 1'b0;
      ptr_data  <= 24'h00_0000;
      wait_cnt  <= 3'h0;
    end
    else
    begin
      ptr_valid <= 1'b0;
      ptr_data  <= {ptr_data[22:0], ~ptr_data[23]};
      if (ptr_req)
      begin
        loc      <= ptr_addr;
        wait_cnt <= slow ? 3'h3 : 3'h1;
      end
      else if (wait_cnt != 3'h0)
      begin
        wait_cnt <= wait_cnt - 3'h1;
        if (wait_cnt == 3'h1)
        begin
          ptr_valid <= 1'b1;
          ptr_data  <= {~loc[7:0], loc[15:0] ^ 16'ha5c3};
        end
      end
    end
endmodule // eag_mem_model
`default_nettype wire

// ### sim/eag_properties.sv
`timescale 1ns/1ps
`default_nettype none
module eag_properties
  import eag_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        start,
  input wire eag_mode_t   mode,
  input wire logic [7:0]  op_byte2,
  input wire logic [7:0]  op_byte3,
  input wire logic [7:0]  op_byte4,
  input wire logic [15:0] index_x,
  input wire logic [15:0] direct_reg,
  input wire logic [15:0] prog_counter,
  input wire logic [23:0] eff_addr,
  input wire logic        addr_valid,
  input wire logic        pc_load,
  input wire logic [15:0] next_pc,
  input wire logic        pbr_load,
  input wire logic [7:0]  data_bank_reg,
  input wire logic        move_step,
  input wire logic [15:0] move_next_x,
  input wire logic        move_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // one-step address forms, answer one cycle after the take
  abs_x_sum_a: assert property (
    start && mode == EAG_ABS_X |=> addr_valid && eff_addr == {data_bank_reg,
    {$past(op_byte3), $past(op_byte2)} + $past(index_x)}) else $error("abs x address wrong");
  long_idx_a: assert property (
    start && mode == EAG_LONG_INDEXED_MODE |=> eff_addr ==
    {$past(op_byte4), $past(op_byte3), $past(op_byte2)} + $past(index_x)) else $error("long indexed wrong");
  abs_long_a: assert property (
    start && mode == EAG_ABS_LONG |=> addr_valid && eff_addr ==
    {$past(op_byte4), $past(op_byte3), $past(op_byte2)}) else $error("absolute long wrong");
  // direct page timing and bank
  dir_fast_a: assert property (
    start && mode == EAG_DIR && direct_reg[7:0] == 8'h00 |=> addr_valid &&
    eff_addr == {8'h00, $past(direct_reg) + {8'h00, $past(op_byte2)}}) else $error("direct address wrong");
  dir_penalty_a: assert property (
    start && mode == EAG_DIR && direct_reg[7:0] != 8'h00 |=> !addr_valid ##1 addr_valid)
    else $error("direct penalty cycle wrong");
  dir_bank0_a: assert property (
    start && mode inside {EAG_DIR_X, EAG_DIR_Y} |-> ##[1:2] (addr_valid && eff_addr[23:16] == 8'h00))
    else $error("direct indexed bank not zero");
  // block move bookkeeping and the long branch
  move_dbr_a: assert property (
    start && mode inside {EAG_BLOCK_MOVE_ASC, EAG_BLOCK_MOVE_DESC} |=> move_step &&
    data_bank_reg == $past(op_byte2)) else $error("block move bank copy wrong");
  move_inc_a: assert property (
    start && mode == EAG_BLOCK_MOVE_ASC |=> move_next_x == $past(index_x) + 16'h0001)
    else $error("ascending index step wrong");
  move_end_a: assert property (
    move_done |-> pc_load && next_pc == $past(prog_counter) + 16'h0003) else $error("move end pc wrong");
  branch_pc_a: assert property (
    start && mode == EAG_BRANCH_LONG |=> pc_load && !pbr_load &&
    next_pc == $past(prog_counter) + {$past(op_byte3), $past(op_byte2)}) else $error("long branch wrong");

  cover property (move_done);
  cover property (pbr_load);
  cover property (addr_valid && eff_addr[23:16] != 8'h00);
endmodule // eag_properties

bind eag_effective_address_generator eag_properties i_props (.clk_sys, .rst_b, .start, .mode,
  .op_byte2, .op_byte3, .op_byte4, .index_x, .direct_reg, .prog_counter, .eff_addr, .addr_valid,
  .pc_load, .next_pc, .pbr_load, .data_bank_reg, .move_step, .move_next_x, .move_done);
`default_nettype wire

// ### sim/eag_effective_address_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module eag_effective_address_generator_test
  import eag_pkg::*;
;
  logic        clk_sys, rst_b, start, wide_mode, ptr_valid, ptr_req, slow;
  logic        addr_valid, operand_valid, pc_load, pbr_load, push_req, move_step, move_done, ptr_long;
  logic [7:0]  op_byte2, op_byte3, op_byte4, program_bank_reg, data_bank_reg;
  logic [15:0] index_x, index_y, direct_reg, accum, prog_counter, operand, next_pc, push_data;
  logic [15:0] move_next_x, move_next_y, move_next_count;
  logic [23:0] ptr_data, eff_addr, ptr_addr;
  eag_mode_t   mode;
  int          num_errors, comparisons, cycles, lat;

  eag_effective_address_generator i_dut (.clk_sys, .rst_b, .start, .mode, .op_byte2, .op_byte3,
    .op_byte4, .wide_mode, .index_x, .index_y, .direct_reg, .accum, .prog_counter, .ptr_valid,
    .ptr_data, .eff_addr, .addr_valid, .ptr_addr, .ptr_req, .ptr_long, .operand, .operand_valid,
    .pc_load, .next_pc, .pbr_load, .program_bank_reg, .data_bank_reg, .push_req, .push_data,
    .move_step, .move_next_x, .move_next_y, .move_next_count, .move_done);
  eag_mem_model i_mem (.clk_sys, .rst_b, .slow, .ptr_req, .ptr_addr, .ptr_valid, .ptr_data);

  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // idle cycle first so start never rises in the step it fell
  task automatic go(input eag_mode_t m);
    @(negedge clk_sys);
    mode  = m;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    lat   = 1;
    while (!(addr_valid | pc_load | operand_valid | push_req | move_step) && lat < 20)
    begin
      @(negedge clk_sys);
      lat++;
    end
  endtask

  task automatic t_move();
    {index_x, index_y, accum, prog_counter} = 64'hffff_0000_0000_2000;
    {op_byte3, op_byte2} = 16'h127e;
    go(EAG_BLOCK_MOVE_ASC);
    check("move src", eff_addr, 32'h0012_ffff);
    check("move dbr", data_bank_reg, 32'h0000_007e);
    check("move xy", {move_next_x, move_next_y}, 32'h0000_0001);
    check("move end", {move_step, move_done, pc_load, next_pc}, 32'h0007_2003);
    check("move cnt", move_next_count, 32'h0000_0000);
    {index_x, index_y, accum} = 48'h0000_0010_0005;
    {op_byte3, op_byte2} = 16'h4403;
    go(EAG_BLOCK_MOVE_DESC);
    check("dmove xy", {move_next_x, move_next_y}, 32'hffff_000f);
    check("dmove cnt", {move_step, move_done, pc_load, move_next_count}, 32'h0004_0004);
  endtask

  // data bank holds 03 from the descending move
  task automatic t_abs();
    {index_x, index_y} = 32'hfff0_0123;
    {op_byte4, op_byte3, op_byte2} = 24'h12_4a20;
    go(EAG_ABS_X);
    check("abs x", eff_addr, 32'h0003_4a10);
    go(EAG_ABS_Y);
    check("abs y", eff_addr, 32'h0003_4b43);
    go(EAG_ABS_LONG);
    check("abs long", eff_addr, 32'h0012_4a20);
    op_byte2 = 8'hf0;
    go(EAG_LONG_INDEXED_MODE);
    check("long x", eff_addr, 32'h0013_4ae0);
  endtask

  task automatic t_dir();
    {direct_reg, op_byte2} = 24'hff00_80;
    go(EAG_DIR);
    check("dir", {lat[7:0], eff_addr}, 32'h0100_ff80);
    go(EAG_DIR_X);
    check("dir x", {lat[7:0], eff_addr}, 32'h0100_ff70);
    go(EAG_DIR_Y);
    check("dir y", {lat[7:0], eff_addr}, 32'h0100_00a3);
    direct_reg = 16'hff01;
    go(EAG_DIR);
    check("dir slow", {lat[7:0], eff_addr}, 32'h0200_ff81);
  endtask

  // alternate prompt and slow memory answers
  task automatic ptr(input eag_mode_t m, input logic [23:0] loc, input logic [23:0] ea);
    slow = ~slow;
    go(m);
    check("ptr loc", ptr_addr, {8'h00, loc});
    check("ptr ea", {addr_valid, eff_addr}, {8'h01, ea});
    check("ptr long", ptr_long, m inside {EAG_DIR_IND_LONG, EAG_DIR_IND_LONG_IDX_Y});
  endtask

  task automatic t_ptr();
    {index_x, index_y, direct_reg, op_byte2} = 56'h0010_fff0_1200_34;
    ptr(EAG_DIR_IDX_IND, 24'h00_1244, 24'h03_b787);
    ptr(EAG_DIR_IND, 24'h00_1234, 24'h03_b7f7);
    ptr(EAG_DIR_IND_IDX_Y, 24'h00_1234, 24'h04_b7e7);
    ptr(EAG_DIR_IND_LONG, 24'h00_1234, 24'hcb_b7f7);
    ptr(EAG_DIR_IND_LONG_IDX_Y, 24'h00_1234, 24'hcc_b7e7);
    {op_byte3, op_byte2} = 16'h5678;
    go(EAG_ABS_IND);
    check("abs ind loc", {ptr_long, ptr_addr}, 32'h0000_5678);
    check("abs ind pc", {pc_load, pbr_load, next_pc}, 32'h0002_f3bb);
    go(EAG_JUMP_LONG_IND);
    check("jml", {pc_load, pbr_load, program_bank_reg, next_pc}, 32'h0387_f3bb);
    check("jml long", ptr_long, 32'h0000_0001);
    // penalty ahead of a pointer read, then none for an absolute pointer
    direct_reg = 16'h1201;
    ptr(EAG_DIR_IND, 24'h00_1279, 24'h03_b7ba);
    go(EAG_ABS_IND);
    check("abs ind lat", {lat[7:0], pc_load, next_pc}, 32'h0009_f3bb);
  endtask

  task automatic t_misc();
    {wide_mode, op_byte3, op_byte2} = 17'h0_beef;
    go(EAG_IMMEDIATE);
    check("imm8", {operand_valid, operand}, 32'h0001_00ef);
    wide_mode = 1'b1;
    go(EAG_IMMEDIATE);
    check("imm16", {operand_valid, operand}, 32'h0001_beef);
    {prog_counter, op_byte3, op_byte2} = 32'h0020_fff0;
    go(EAG_BRANCH_LONG);
    check("brl", {pc_load, pbr_load, push_req, next_pc}, 32'h0004_0010);
    go(EAG_PUSH_RELATIVE_ADDRESS);
    check("push rel", {push_req, pc_load, push_data}, 32'h0002_0010);
  endtask

  initial
  begin
    {start, slow, wide_mode, rst_b} = 4'h0;
    mode = EAG_DIR;
    {op_byte4, op_byte3, op_byte2} = 24'h00_0000;
    {index_x, index_y, direct_reg, accum, prog_counter} = 80'h0000;
    repeat (20) @(negedge clk_sys);
    check("reset", {addr_valid, pc_load, data_bank_reg, program_bank_reg}, 32'h0000_0000);
    rst_b = 1'b1;
    t_move();
    t_abs();
    t_dir();
    t_ptr();
    // reset in mid-run clears the bank registers again
    @(negedge clk_sys);
    rst_b = 1'b0;
    @(negedge clk_sys);
    check("mid reset", {pc_load, data_bank_reg, program_bank_reg}, 32'h0000_0000);
    rst_b = 1'b1;
    t_misc();
    print_verdict();
  end
endmodule // eag_effective_address_generator_test
`default_nettype wire
